// ===== design/scpe_pkg.sv
// Package for the serial control port front end.
// Assumes a 20 MHz system clock and a host-driven serial link.
package scpe_pkg;

  // ----------------------------------------
  // Frame and register layout
  // ----------------------------------------
  localparam int          FRAME_BITS     = 24;
  localparam int          CNT_W          = 5;
  localparam int          ADDR_W         = 4;
  localparam int          DATA_W         = 16;
  localparam int          REG_COUNT      = 16;
  localparam int          POS_RW         = 23;
  localparam int          POS_ADDR_HI    = 19;
  localparam int          POS_ADDR_LO    = 16;
  localparam logic [3:0]  CTRL_ADDR      = 4'h0;
  localparam int          CTRL_INTERLEAVE = 7;
  localparam int          CTRL_CAL       = 1;
  localparam logic [15:0] REG_RESET_VAL  = 16'h0000;
  localparam logic [4:0]  CNT_RESET      = 5'h00;
  localparam logic [3:0]  PIN_IDLE       = 4'ha;

  typedef enum logic [1:0] {
    SCPE_IDLE,
    SCPE_SHIFT,
    SCPE_DONE
  } scpe_state_t;

endpackage : scpe_pkg

// ===== design/scpe_pin_if.sv
// Interface carrying synchronised link levels and edge strobes.
// Assumes one producer (pin synchroniser) and one consumer (main block).
`timescale 1ns/1ns
`default_nettype none
interface scpe_pin_if;
  logic selectN;
  logic dataIn;
  logic clkRise;
  logic clkFall;
  logic enableN;
  modport producer (output selectN, output dataIn, output clkRise, output clkFall, output enableN);
  modport consumer (input selectN, input dataIn, input clkRise, input clkFall, input enableN);
endinterface : scpe_pin_if
`default_nettype wire

// ===== design/scpe_pin_sync.sv
// Three-stage synchronisers for the pins from the host, with edge strobes.
// Assumes all pin inputs are asynchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module scpe_pin_sync
  import scpe_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  input  wire logic          clkEn,
  input  wire logic          serialClk,
  input  wire logic          serialSelectN,
  input  wire logic          serialIn,
  input  wire logic          extendedControlEnableN,
  scpe_pin_if.producer       pins
);
  import scpe_pkg::*;

  // ----------------------------------------
  // Per-pin three-flop chains
  // ----------------------------------------
  logic [3:0] rawIn;
  logic [3:0] stable;
  assign rawIn = {extendedControlEnableN, serialIn, serialSelectN, serialClk};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gSync
      logic [2:0] sync_q;
      logic [2:0] sync_d;
      logic       stable_q;
      logic       stable_d;
      always_comb begin
        sync_d   = {sync_q[1:0], rawIn[g]};
        // Accept a change only once stages two and three agree
        stable_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : stable_q;
      end
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          // Whole chain at idle level, else a false select or enable follows reset
          sync_q   <= {3{PIN_IDLE[g]}};
          stable_q <= PIN_IDLE[g];
        end else if (clkEn) begin
          sync_q   <= sync_d;
          stable_q <= stable_d;
        end
      end
      assign stable[g] = stable_q;
    end
  endgenerate

  logic clkPrev_q;
  logic clkPrev_d;
  always_comb clkPrev_d = stable[0];
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clkPrev_q <= 1'b0;
    end else if (clkEn) begin
      clkPrev_q <= clkPrev_d;
    end
  end

  assign pins.clkRise = clkEn & stable[0] & ~clkPrev_q;
  assign pins.clkFall = clkEn & ~stable[0] & clkPrev_q;
  assign pins.selectN = stable[1];
  assign pins.dataIn  = stable[2];
  assign pins.enableN = stable[3];
endmodule : scpe_pin_sync
`default_nettype wire

// ===== design/scpe_serial_port.sv
// Serial control port front end with register bank and pin/register muxing.
// Assumes host is serial master; serial clock is sampled by clk_sys.
// Frame: rw bit, 3 spare, 4 address bits, 16 data bits, MSB first.
// How it works
// R1: Serial register control works only while the enable pin is low.
// R2: With control enabled, direct mode pins yield to register settings.
// R3: Enable pin high disables the port; settings come from pins.
// R4: Enable pin high holds every register at its default.
// R5: Select low frames a transfer; serial clock shifts in and out.
// R6: Select high ignores serial input and floats serial output.
// R7: Shifting follows only host serial clock edges.
// R8: Host may park serial clock low between transfers.
// R9: Calibration request is pin OR control bit; low-to-high starts it.
// R10: Interleave mode from control bit 7 when enabled; default off.
// R11: Input sampled on rising clock edge, output changed on falling.
`timescale 1ns/1ns
`default_nettype none
module scpe_serial_port
  import scpe_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic clkEn,
  input  wire logic serialClk,
  input  wire logic serialSelectN,
  input  wire logic serialIn,
  input  wire logic extendedControlEnableN,
  input  wire logic calRequestPin,
  input  wire logic interleaveModePin,
  output logic      serialOut,
  output logic      serialOutEnN,
  output logic      extendedControlMode,
  output logic      interleaveMode,
  output logic      calStart,
  output logic      calRequest,
  output logic [15:0] controlWord
);
  import scpe_pkg::*;

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  scpe_pin_if pins ();

  scpe_pin_sync uSync (
    .clk_sys                (clk_sys),
    .sys_rst                (sys_rst),
    .clkEn                  (clkEn),
    .serialClk              (serialClk),
    .serialSelectN          (serialSelectN),
    .serialIn               (serialIn),
    .extendedControlEnableN (extendedControlEnableN),
    .pins                   (pins)
  );

  logic portOn;
  assign portOn = ~pins.enableN; // [R1]

  // ----------------------------------------
  // Shift engine state
  // ----------------------------------------
  scpe_state_t             state_q, state_d;
  logic [CNT_W-1:0]        bitCnt_q, bitCnt_d;
  logic [FRAME_BITS-1:0]   shiftIn_q, shiftIn_d;
  logic [DATA_W-1:0]       shiftOut_q, shiftOut_d;
  logic                    out_q, out_d;
  logic                    outEnN_q, outEnN_d;
  logic                    isRead_q, isRead_d;
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic                    wrStrobe;
  logic [DATA_W-1:0]       regs_q [REG_COUNT];
  logic [DATA_W-1:0]       regs_d [REG_COUNT];

  logic active;
  assign active = portOn & ~pins.selectN; // [R5] [R6]

  always_comb begin
    state_d    = state_q;
    bitCnt_d   = bitCnt_q;
    shiftIn_d  = shiftIn_q;
    shiftOut_d = shiftOut_q;
    out_d      = out_q;
    outEnN_d   = outEnN_q;
    isRead_d   = isRead_q;
    addr_d     = addr_q;
    wrStrobe   = 1'b0;
    if (!active) begin
      // Abandoned frames are dropped, never half-written
      state_d  = SCPE_IDLE;
      bitCnt_d = CNT_RESET;
      outEnN_d = 1'b1; // [R6]
      out_d    = 1'b0;
    end else begin
      outEnN_d = 1'b0; // [R5]
      case (state_q)
        SCPE_IDLE: begin
          state_d  = SCPE_SHIFT;
          bitCnt_d = CNT_RESET;
        end
        SCPE_SHIFT: begin
          if (pins.clkRise) begin // [R7] [R11]
            shiftIn_d = {shiftIn_q[FRAME_BITS-2:0], pins.dataIn};
            bitCnt_d  = bitCnt_q + 5'h01;
            if (bitCnt_q == 5'(POS_RW - POS_ADDR_LO)) begin
              // Address complete: latch it and preload read data
              isRead_d   = shiftIn_q[POS_RW - POS_ADDR_LO - 1];
              addr_d     = {shiftIn_q[2:0], pins.dataIn};
              shiftOut_d = regs_q[{shiftIn_q[2:0], pins.dataIn}];
            end
            if (bitCnt_q == 5'(FRAME_BITS - 1)) begin
              state_d  = SCPE_DONE;
              wrStrobe = ~isRead_q;
            end
          end
          if (pins.clkFall && bitCnt_q > 5'(POS_RW - POS_ADDR_LO)) begin // [R11]
            out_d      = isRead_q & shiftOut_q[DATA_W-1];
            shiftOut_d = {shiftOut_q[DATA_W-2:0], 1'b0};
          end
        end
        SCPE_DONE: begin
          // Extra clocks past the frame are ignored until select rises
          state_d = SCPE_DONE;
        end
        default: state_d = SCPE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q    <= SCPE_IDLE;
      bitCnt_q   <= CNT_RESET;
      shiftIn_q  <= '0;
      shiftOut_q <= '0;
      out_q      <= 1'b0;
      outEnN_q   <= 1'b1;
      isRead_q   <= 1'b0;
      addr_q     <= '0;
    end else if (clkEn) begin
      state_q    <= state_d;
      bitCnt_q   <= bitCnt_d;
      shiftIn_q  <= shiftIn_d;
      shiftOut_q <= shiftOut_d;
      out_q      <= out_d;
      outEnN_q   <= outEnN_d;
      isRead_q   <= isRead_d;
      addr_q     <= addr_d;
    end
  end

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      regs_d[i] = regs_q[i];
      if (!portOn) begin
        regs_d[i] = REG_RESET_VAL; // [R4]
      end else if (wrStrobe && addr_q == ADDR_W'(i)) begin
        regs_d[i] = {shiftIn_q[DATA_W-2:0], pins.dataIn};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < REG_COUNT; i++) begin
      if (sys_rst) begin
        regs_q[i] <= REG_RESET_VAL;
      end else if (clkEn) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ----------------------------------------
  // Mode selection and calibration
  // ----------------------------------------
  logic [DATA_W-1:0] ctrl;
  logic calPrev_q, calPrev_d;
  logic calArmed_q, calArmed_d;
  logic calOr;
  logic modeOut_q, modeOut_d;
  logic calStart_q, calStart_d;
  logic ecm_q, ecm_d;
  logic [DATA_W-1:0] ctrlOut_q, ctrlOut_d;

  assign ctrl = regs_q[CTRL_ADDR];

  always_comb begin
    // Pin-level calibration line is treated as same-domain logic
    calOr      = calRequestPin | (portOn & ctrl[CTRL_CAL]); // [R9]
    calPrev_d  = calOr;
    calArmed_d = calArmed_q;
    calStart_d = 1'b0;
    if (!calOr) begin
      calArmed_d = 1'b1; // [R9]
    end else if (!calPrev_q && calArmed_q) begin
      calStart_d = 1'b1; // [R9]
      calArmed_d = 1'b0;
    end
    // Pin wins outside extended control, register bit inside
    modeOut_d = portOn ? ctrl[CTRL_INTERLEAVE] : interleaveModePin; // [R2] [R3] [R10]
    ecm_d     = portOn;
    ctrlOut_d = ctrl;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      calPrev_q  <= 1'b1;
      calArmed_q <= 1'b0;
      calStart_q <= 1'b0;
      modeOut_q  <= 1'b0;
      ecm_q      <= 1'b0;
      ctrlOut_q  <= REG_RESET_VAL;
    end else if (clkEn) begin
      calPrev_q  <= calPrev_d;
      calArmed_q <= calArmed_d;
      calStart_q <= calStart_d;
      modeOut_q  <= modeOut_d;
      ecm_q      <= ecm_d;
      ctrlOut_q  <= ctrlOut_d;
    end
  end

  assign serialOut           = out_q;
  assign serialOutEnN        = outEnN_q;
  assign extendedControlMode = ecm_q;
  assign interleaveMode      = modeOut_q;
  assign calStart            = calStart_q;
  assign calRequest          = calPrev_q;
  assign controlWord         = ctrlOut_q;
endmodule : scpe_serial_port
`default_nettype wire

// ===== testbench/scpe_port_asserts.sv
// Checker on the serial port top-level pins.
// Checks pause while clkEn is low; bound onto scpe_serial_port.
`timescale 1ns/1ns
`default_nettype none
module scpe_port_asserts
  import scpe_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        clkEn,
  input wire logic        serialSelectN,
  input wire logic        extendedControlEnableN,
  input wire logic        calRequestPin,
  input wire logic        interleaveModePin,
  input wire logic        serialOutEnN,
  input wire logic        extendedControlMode,
  input wire logic        interleaveMode,
  input wire logic        calStart,
  input wire logic        calRequest,
  input wire logic [15:0] controlWord
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst || !clkEn);
  // Windows of 8 cover the pin synchroniser plus output register
  oe_float_a: assert property (serialSelectN [*8] |-> serialOutEnN)
    else $error("output driven while deselected");
  oe_off_a: assert property (extendedControlEnableN [*8] |-> serialOutEnN && !extendedControlMode)
    else $error("port active while disabled");
  oe_drive_a: assert property ((!serialSelectN && !extendedControlEnableN) [*8] |-> !serialOutEnN)
    else $error("output not driven in frame");
  ecm_on_a: assert property (!extendedControlEnableN [*8] |-> extendedControlMode)
    else $error("register control not active");
  regs_clear_a: assert property (extendedControlEnableN [*8] |-> controlWord == REG_RESET_VAL)
    else $error("register not at default");
  pin_mode_a: assert property ((extendedControlEnableN && $stable(interleaveModePin)) [*8] |->
    interleaveMode == interleaveModePin) else $error("mode not from pin");
  reg_mode_a: assert property ((!extendedControlEnableN && $stable(controlWord)) [*8] |->
    interleaveMode == controlWord[CTRL_INTERLEAVE]) else $error("mode not from register");
  cal_or_a: assert property (($stable(calRequestPin) && $stable(controlWord) && $stable(extendedControlEnableN)) [*6] |->
    calRequest == (calRequestPin | controlWord[CTRL_CAL])) else $error("request not pin or bit");
  cal_pulse_a: assert property (calStart |=> !calStart)
    else $error("start longer than one cycle");
  cal_arm_a: assert property (calRequest [*8] |-> !calStart)
    else $error("start without low phase");
  cover property (calStart);
  cover property (!serialOutEnN);
  cover property (interleaveMode && extendedControlMode);
endmodule : scpe_port_asserts
`default_nettype wire

// ===== testbench/scpe_host_model.sv
// Host serial master: frames, link clock, read capture.
// Assumes clk_sys of 50 ns; link half period is 4 cycles.
`timescale 1ns/1ns
`default_nettype none
module scpe_host_model (
  input  wire logic clk_sys,
  input  wire logic serialOut,
  output var logic  serialClk,
  output var logic  serialSelectN,
  output var logic  serialIn
);
  initial begin
    serialClk = 1'b0;
    serialSelectN = 1'b1;
    serialIn = 1'b0;
  end
  // Fewer than 24 bits aborts the frame midway
  task automatic xfer(input logic [23:0] frame, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge clk_sys);
    serialSelectN <= 1'b0;
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < nbits; i++) begin
      serialIn <= frame[23 - i];
      repeat (4) @(posedge clk_sys);
      serialClk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      // Synchroniser lag: sample late in the high half
      rd = {rd[14:0], serialOut};
      serialClk <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
    serialSelectN <= 1'b1;
    serialIn <= ~serialIn; // Released line shows no stale value
    // Select must stay high past the pin filter before the next frame
    repeat (8) @(posedge clk_sys);
  endtask : xfer
endmodule : scpe_host_model
`default_nettype wire

// ===== testbench/tb_serial_control_port_enable.sv
// Top bench: host model, reference registers, verdict.
// Assumes design top scpe_serial_port with plain ports.
`timescale 1ns/1ns
`default_nettype none
module tb_serial_control_port_enable;
  import scpe_pkg::*;
  logic        clk_sys, sys_rst, clkEn, extendedControlEnableN, calRequestPin, interleaveModePin;
  wire logic   serialClk, serialSelectN, serialIn;
  logic        serialOut, serialOutEnN, extendedControlMode, interleaveMode, calStart, calRequest;
  logic [15:0] controlWord, rdData;
  logic [15:0] model [16];
  logic [31:0] lfsrQ = 32'h8d70;
  int          fails = 0;
  int          n_tests = 0;
  int          calCount = 0;
  scpe_serial_port u_scpe_serial_port (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
    .serialClk(serialClk), .serialSelectN(serialSelectN), .serialIn(serialIn),
    .extendedControlEnableN(extendedControlEnableN), .calRequestPin(calRequestPin),
    .interleaveModePin(interleaveModePin), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
    .extendedControlMode(extendedControlMode), .interleaveMode(interleaveMode), .calStart(calStart),
    .calRequest(calRequest), .controlWord(controlWord));
  scpe_host_model u_scpe_host_model (.clk_sys(clk_sys), .serialOut(serialOut), .serialClk(serialClk),
    .serialSelectN(serialSelectN), .serialIn(serialIn));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : check
  task automatic finish_test();
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    logic [31:0] v;
    v = s;
    for (int k = 0; k < 16; k++) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    return v;
  endfunction : lfsr_next
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    u_scpe_host_model.xfer({1'b0, 3'h0, a, d}, 24, rdData);
    if (extendedControlEnableN == 1'b0) model[a] = d;
    repeat (3) @(negedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    u_scpe_host_model.xfer({1'b1, 3'h0, a, 16'h0000}, 24, rdData);
    check("readData", model[a], rdData);
  endtask : rd
  task automatic setPins(input logic en, input logic cal, input logic ilv);
    @(posedge clk_sys);
    extendedControlEnableN <= en;
    calRequestPin <= cal;
    interleaveModePin <= ilv;
    repeat (12) @(negedge clk_sys);
  endtask : setPins
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    if (calStart === 1'b1) calCount++;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    finish_test();
  end
  initial begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    extendedControlEnableN = 1'b1;
    calRequestPin = 1'b0;
    interleaveModePin = 1'b0;
    foreach (model[i]) model[i] = REG_RESET_VAL;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    setPins(1'b1, 1'b0, 1'b1);
    check("interleaveMode", 16'h0001, 16'(interleaveMode));
    check("serialOutEnN", 16'h0001, 16'(serialOutEnN));
    setPins(1'b0, 1'b0, 1'b1);
    check("mode", 16'h0001, 16'(extendedControlMode));
    check("interleaveMode", 16'h0000, 16'(interleaveMode));
    wr(CTRL_ADDR, 16'h0080);
    check("controlWord", model[0], controlWord);
    check("interleaveMode", 16'h0001, 16'(interleaveMode));
    setPins(1'b0, 1'b1, 1'b0);
    check("calStarts", 16'h0001, 16'(calCount));
    setPins(1'b0, 1'b0, 1'b0);
    wr(CTRL_ADDR, 16'h0002);
    check("calStarts", 16'h0002, 16'(calCount));
    setPins(1'b0, 1'b1, 1'b0);
    check("calStarts", 16'h0002, 16'(calCount));
    setPins(1'b0, 1'b0, 1'b0);
    wr(CTRL_ADDR, 16'h0000);
    // Low clock enable must hold off a start until it returns
    @(posedge clk_sys);
    clkEn <= 1'b0;
    calRequestPin <= 1'b1;
    repeat (12) @(negedge clk_sys);
    check("calRequest", 16'h0000, 16'(calRequest));
    check("calStarts", 16'h0002, 16'(calCount));
    @(posedge clk_sys);
    clkEn <= 1'b1;
    repeat (12) @(negedge clk_sys);
    check("calStarts", 16'h0003, 16'(calCount));
    setPins(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      lfsrQ = lfsr_next(lfsrQ);
      wr(lfsrQ[3:0] | 4'h1, lfsrQ[31:16]);
    end
    for (int a = 1; a < 16; a += 2) rd(4'(a));
    wr(4'h3, 16'ha5c3);
    u_scpe_host_model.xfer({1'b0, 3'h0, 4'h3, 16'h5a5a}, 20, rdData);
    rd(4'h3);
    wr(CTRL_ADDR, 16'h0080);
    setPins(1'b1, 1'b0, 1'b0);
    foreach (model[i]) model[i] = REG_RESET_VAL;
    check("controlWord", 16'h0000, controlWord);
    check("interleaveMode", 16'h0000, 16'(interleaveMode));
    wr(4'h3, 16'h1234);
    setPins(1'b0, 1'b0, 1'b0);
    rd(4'h3);
    finish_test();
  end
endmodule : tb_serial_control_port_enable
bind scpe_serial_port scpe_port_asserts u_scpe_port_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
  .serialSelectN(serialSelectN), .extendedControlEnableN(extendedControlEnableN),
  .calRequestPin(calRequestPin), .interleaveModePin(interleaveModePin), .serialOutEnN(serialOutEnN),
  .extendedControlMode(extendedControlMode), .interleaveMode(interleaveMode), .calStart(calStart),
  .calRequest(calRequest), .controlWord(controlWord));
`default_nettype wire
